// ### rtl/fsw_status.v
`timescale 1ns/1ps
`include "fsw_defines.vh"

// Behaviour
// [RL1] Status read repeats the register value until chip select rises.
// [RL2] Bit 0 shows busy while an internal write cycle runs.
// [RL3] Bit 1 shows the write-enable latch, reset to zero.
// [RL4] Bits 2 to 5 are non-volatile writable block-protect bits.
// [RL5] Bit 6 is the non-volatile quad enable, default zero.
// [RL6] Bit 7 is the non-volatile status write lock.
// [RL7] Status write changes bits 2 to 7 only, never the latch.
// [RL8] Non-volatile bits start cleared; the code clears them in reset, then loads nv_image one cycle later.
// [RL9] Busy rises for program, erase, register writes; falls on completion.
// [RL10] While busy only status read, resets and suspend are accepted.
// [RL11] Suspend is accepted during busy program or erase.
// [RL12] Write-enable command sets the latch.
// [RL13] Latch at zero blocks all write-class commands.
// [RL14] Write-disable command clears the latch.
// [RL15] Latch clears when a register write, program or erase completes.
// [RL16] Host issues write enable before write-class commands.
// [RL17] Table byte 80h reports the supported read and program commands.
// [RL18] Table bits 9 to 12 report erase types, option swaps 3 and 4.
// [RL19] Table bits 13 to 15 report the double-rate reads.
// [RL20] Table reports sector lock commands; reserved bits read ones.
// [RL21] Table bytes 84h to 87h hold the erase opcodes.
// [RL22] Lock bit with protect pin low makes status writes ignored.
// [RL23] Full array erase ignored unless all block-protect bits are zero.
// [RL24] Quad enable turns protect and hold pins into data lines.
// [RL25] Non-volatile bits survive power loss; busy and latch reset.
module fsw_status #(
    parameter LARGE_BLOCK = 0
) (
    input  wire       clk,
    input  wire       nrst,
    input  wire       sck,
    input  wire       cs_n,
    input  wire       si,
    input  wire       wp_n,
    output reg        so,
    output reg        so_oe_n,
    input  wire [5:0] nv_image,
    input  wire       op_done,
    output reg        op_start,
    output reg  [7:0] op_code,
    output reg  [7:0] nv_wdata,
    output reg        suspend,
    output reg        sw_reset,
    output reg        write_busy,
    output reg        write_enable_latch,
    output reg  [5:0] nv_bits,
    output reg        pin_ctl_en
);

    // ============================================================
    // Frame states
    localparam [5:0] ST_CMD   = 6'h01;
    localparam [5:0] ST_ADDR  = 6'h02;
    localparam [5:0] ST_DUMMY = 6'h04;
    localparam [5:0] ST_DOUT  = 6'h08;
    localparam [5:0] ST_WDATA = 6'h10;
    localparam [5:0] ST_IGN   = 6'h20;

    // ============================================================
    // Opcode classes
    function is_pe;
        input [7:0] op;
        begin
            case (op)
                8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3e,
                8'h20, 8'hd7, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc,
                `FSW_OP_CE_A, `FSW_OP_CE_B: is_pe = 1'b1;
                default: is_pe = 1'b0;
            endcase
        end
    endfunction

    function is_susp;
        input [7:0] op;
        begin
            is_susp = (op == `FSW_OP_SUSP_A) || (op == `FSW_OP_SUSP_B);
        end
    endfunction

    // ============================================================
    // Pin synchronisation
    wire [3:0] pin_lvl;
    wire       sck_f;
    wire       cs_n_f;
    wire       si_f;
    wire       wp_n_f;

    fsw_pin_sync #(
        .WIDTH (4),
        .INIT  (4'ha)
    ) u_sync (
        .clk       (clk),
        .nrst      (nrst),
        .pin_in    ({wp_n, si, cs_n, sck}),
        .level_out (pin_lvl)
    );

    assign sck_f  = pin_lvl[0];
    assign cs_n_f = pin_lvl[1];
    assign si_f   = pin_lvl[2];
    assign wp_n_f = pin_lvl[3];

    // ============================================================
    // State
    reg        sck_d_r;
    reg        cs_n_d_r;
    reg [5:0]  state_r;
    reg [2:0]  bit_cnt_r;
    reg [1:0]  byte_cnt_r;
    reg [7:0]  sh_in_r;
    reg [7:0]  sh_out_r;
    reg [7:0]  opcode_r;
    reg [7:0]  wdata_r;
    reg [23:0] addr_r;
    reg        cmd_ok_r;
    reg        wr_full_r;
    reg        load_pend_r;
    reg        src_rom_r;
    reg        rst_en_r;
    reg        busy_pe_r;
    reg        boot_load_r;
    wire [7:0] rom_q;

    fsw_param_rom #(
        .LARGE_BLOCK (LARGE_BLOCK)
    ) u_rom (
        .clk     (clk),
        .nrst    (nrst),
        .addr    (addr_r),
        .rd_data (rom_q)
    );

    // ============================================================
    // Derived terms
    wire       sck_rise = sck_f & ~sck_d_r & ~cs_n_f;
    wire       sck_fall = ~sck_f & sck_d_r & ~cs_n_f;
    wire       cs_rise  = cs_n_f & ~cs_n_d_r;
    wire [7:0] byte_in  = {sh_in_r[6:0], si_f};
    wire       last_bit = (bit_cnt_r == `FSW_BIT_LAST);
    wire [7:0] status   = {nv_bits, write_enable_latch, write_busy}; // see [RL2] see [RL3]
    wire [7:0] out_src  = src_rom_r ? rom_q : status;
    // With quad enable set, the protect pin is a data line and not a lock.
    wire       wr_lock  = nv_bits[`FSW_ST_LOCK - 2] & ~wp_n_f
                          & ~nv_bits[`FSW_ST_QUAD - 2];           // see [RL22] see [RL24]
    wire [3:0] bp_bits  = nv_bits[`FSW_ST_BP_HI - 2:0];

    // Commands accepted while busy.
    wire       busy_ok  = (byte_in == `FSW_OP_RDSR) || (byte_in == `FSW_OP_RSTEN)
                          || (byte_in == `FSW_OP_RST)
                          || (is_susp(byte_in) && busy_pe_r);     // see [RL10] see [RL11]

    // ============================================================
    // Edge history for the synchronised pins.
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sck_d_r  <= 1'b0;
            cs_n_d_r <= 1'b1;
        end
        else
        begin
            sck_d_r  <= sck_f;
            cs_n_d_r <= cs_n_f;
        end
    end

    // ============================================================
    // Serial receive and frame sequencing.
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r    <= ST_CMD;
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 2'h0;
            sh_in_r    <= 8'h00;
            opcode_r   <= 8'h00;
            wdata_r    <= 8'h00;
            addr_r     <= 24'h000000;
            cmd_ok_r   <= 1'b0;
            wr_full_r  <= 1'b0;
            src_rom_r  <= 1'b0;
        end
        else if (cs_n_f)
        begin
            // Deselected: the next frame starts from a clean slate.
            state_r    <= ST_CMD;
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 2'h0;
            if (!cs_rise)
            begin
                cmd_ok_r  <= 1'b0;
                wr_full_r <= 1'b0;
            end
        end
        else if (sck_rise)
        begin
            sh_in_r   <= byte_in;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (last_bit)
            begin
                case (state_r)
                    ST_CMD:
                    begin
                        opcode_r  <= byte_in;
                        cmd_ok_r  <= ~write_busy | busy_ok;        // see [RL10]
                        src_rom_r <= 1'b0;
                        if (write_busy && !busy_ok)
                            state_r <= ST_IGN;
                        else if (byte_in == `FSW_OP_RDSR)
                            state_r <= ST_DOUT;                    // see [RL1]
                        else if (byte_in == `FSW_OP_SFDP)
                            state_r <= ST_ADDR;
                        else if (byte_in == `FSW_OP_ST_WR)
                            state_r <= ST_WDATA;
                        else
                            state_r <= ST_IGN;
                    end
                    ST_ADDR:
                    begin
                        addr_r     <= {addr_r[15:0], byte_in};
                        byte_cnt_r <= byte_cnt_r + 2'h1;
                        if (byte_cnt_r == `FSW_ADDR_BYTES - 2'h1)
                            state_r <= ST_DUMMY;
                    end
                    ST_DUMMY:
                    begin
                        src_rom_r <= 1'b1;
                        state_r   <= ST_DOUT;
                    end
                    ST_DOUT:
                    begin
                        if (src_rom_r)
                            addr_r <= addr_r + 24'h000001;
                    end
                    ST_WDATA:
                    begin
                        wdata_r   <= byte_in;
                        wr_full_r <= 1'b1;
                        state_r   <= ST_IGN;
                    end
                    ST_IGN:
                        state_r <= ST_IGN;
                    default:
                        state_r <= ST_IGN;
                endcase
            end
        end
    end

    // ============================================================
    // Serial transmit; data change on the falling clock edge.
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            so          <= 1'b0;
            so_oe_n     <= 1'b1;
            sh_out_r    <= 8'h00;
            load_pend_r <= 1'b0;
        end
        else if (cs_n_f)
        begin
            so_oe_n     <= 1'b1;
            load_pend_r <= 1'b0;
        end
        else
        begin
            // A completed byte in the output phase queues the next one.
            if (sck_rise && last_bit
                && ((state_r == ST_DUMMY) || (state_r == ST_DOUT)
                    || ((state_r == ST_CMD) && (byte_in == `FSW_OP_RDSR)
                        && (!write_busy || busy_ok))))
                load_pend_r <= 1'b1;
            else if (sck_fall && load_pend_r)
                load_pend_r <= 1'b0;
            if (sck_fall && (state_r == ST_DOUT))
            begin
                so_oe_n <= 1'b0;
                if (load_pend_r)
                begin
                    // Status is reloaded every byte so it repeats live.
                    so       <= out_src[7];                        // see [RL1]
                    sh_out_r <= {out_src[6:0], 1'b0};
                end
                else
                begin
                    so       <= sh_out_r[7];
                    sh_out_r <= {sh_out_r[6:0], 1'b0};
                end
            end
        end
    end

    // ============================================================
    // Command execution at chip-select release.
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            write_busy         <= 1'b0;                            // see [RL25]
            write_enable_latch <= 1'b0;                            // see [RL25]
            nv_bits            <= `FSW_NV_RESET;                   // see [RL8]
            boot_load_r        <= 1'b1;
            op_start           <= 1'b0;
            op_code            <= 8'h00;
            nv_wdata           <= `FSW_ST_RESET;
            suspend            <= 1'b0;
            sw_reset           <= 1'b0;
            rst_en_r           <= 1'b0;
            busy_pe_r          <= 1'b0;
        end
        else
        begin
            op_start <= 1'b0;
            suspend  <= 1'b0;
            sw_reset <= 1'b0;
            // Non-volatile image is taken from the store after reset.
            if (boot_load_r)
            begin
                boot_load_r <= 1'b0;
                nv_bits     <= nv_image;                           // see [RL25]
            end
            // Completion, pass or fail, ends busy and drops the latch.
            if (op_done && write_busy)
            begin
                write_busy         <= 1'b0;                        // see [RL9]
                write_enable_latch <= 1'b0;                        // see [RL15]
                busy_pe_r          <= 1'b0;
            end
            if (cs_rise && cmd_ok_r && (bit_cnt_r == 3'h0))
            begin
                rst_en_r <= (opcode_r == `FSW_OP_RSTEN);
                if (opcode_r == `FSW_OP_WR_EN)
                    write_enable_latch <= 1'b1;                    // see [RL12]
                else if (opcode_r == `FSW_OP_WR_DIS)
                    write_enable_latch <= 1'b0;                    // see [RL14]
                else if (opcode_r == `FSW_OP_RST)
                begin
                    if (rst_en_r)
                    begin
                        sw_reset           <= 1'b1;
                        write_enable_latch <= 1'b0;
                    end
                end
                else if (is_susp(opcode_r))
                begin
                    if (busy_pe_r)
                        suspend <= 1'b1;                           // see [RL11]
                end
                else if (opcode_r == `FSW_OP_ST_WR)
                begin
                    // Only bits 7:2 are written; the latch is untouched.
                    if (wr_full_r && write_enable_latch && !wr_lock) // see [RL13] see [RL22]
                    begin
                        nv_bits    <= wdata_r[7:2];                // see [RL4] see [RL5]
                        nv_wdata   <= {wdata_r[7:2], 2'b00};       // see [RL6] see [RL7]
                        op_code    <= opcode_r;
                        op_start   <= 1'b1;
                        write_busy <= 1'b1;                        // see [RL9]
                    end
                end
                else if (is_pe(opcode_r) && write_enable_latch)    // see [RL13] see [RL16]
                begin
                    if (!(((opcode_r == `FSW_OP_CE_A) || (opcode_r == `FSW_OP_CE_B))
                          && (bp_bits != 4'h0)))                   // see [RL23]
                    begin
                        op_code    <= opcode_r;
                        op_start   <= 1'b1;
                        write_busy <= 1'b1;                        // see [RL9]
                        busy_pe_r  <= 1'b1;
                    end
                end
            end
        end
    end

    // ============================================================
    // Pin function select follows quad enable.
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pin_ctl_en <= 1'b1;
        else
            pin_ctl_en <= ~nv_bits[`FSW_ST_QUAD - 2];              // see [RL24]
    end

endmodule // fsw_status

// ### rtl/fsw_defines.vh
`ifndef FSW_DEFINES_VH
`define FSW_DEFINES_VH

// ============================================================
// Status register field positions and reset value
`define FSW_ST_BUSY          0
`define FSW_ST_LATCH         1
`define FSW_ST_BP_LO         2
`define FSW_ST_BP_HI         5
`define FSW_ST_QUAD          6
`define FSW_ST_LOCK          7
`define FSW_ST_RESET         8'h00
`define FSW_NV_RESET         6'h00

// ============================================================
// Command opcodes
`define FSW_OP_WR_EN         8'h06
`define FSW_OP_WR_DIS        8'h04
`define FSW_OP_RDSR          8'h05
`define FSW_OP_ST_WR         8'h01
`define FSW_OP_SFDP          8'h5a
`define FSW_OP_RSTEN         8'h66
`define FSW_OP_RST           8'h99
`define FSW_OP_SUSP_A        8'h75
`define FSW_OP_SUSP_B        8'hb0
`define FSW_OP_CE_A          8'hc7
`define FSW_OP_CE_B          8'h60

// ============================================================
// Parameter table window and contents
`define FSW_TBL_BASE         21'h000010
`define FSW_TBL_FILL         8'hff
`define FSW_TBL_B80          8'hff
`define FSW_TBL_B81_STD      8'hee
`define FSW_TBL_B81_LB       8'hf6
`define FSW_TBL_B82          8'hff
`define FSW_TBL_B83          8'hff
`define FSW_TBL_ER1          8'h21
`define FSW_TBL_ER2          8'h5c
`define FSW_TBL_ER3          8'hdc
`define FSW_TBL_ER4          8'hff

// ============================================================
// Frame sequencing counts
`define FSW_ADDR_BYTES       2'h3
`define FSW_BIT_LAST         3'h7

`endif

// ### rtl/fsw_pin_sync.v
`timescale 1ns/1ps

// ============================================================
// Three-stage pin synchroniser; the output follows only once
// the second and third stages agree.
module fsw_pin_sync #(
    parameter             WIDTH = 4,
    parameter [WIDTH-1:0] INIT  = {WIDTH{1'b1}}
) (
    input  wire             clk,
    input  wire             nrst,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] level_out
);

    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    reg [WIDTH-1:0] level_r;

    // Stage chain and agreement filter per bit.
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_r    <= INIT;
            s2_r    <= INIT;
            s3_r    <= INIT;
            level_r <= INIT;
        end
        else
        begin
            s1_r    <= pin_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= (s2_r & s3_r) | (level_r & (s2_r ^ s3_r));
        end
    end

    assign level_out = level_r;

endmodule // fsw_pin_sync

// ### rtl/fsw_param_rom.v
`timescale 1ns/1ps
`include "fsw_defines.vh"

// ============================================================
// Constant 3-byte-address parameter table with registered output.
module fsw_param_rom #(
    parameter LARGE_BLOCK = 0
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire [23:0] addr,
    output reg  [7:0]  rd_data
);

    reg [7:0] word_nxt;

    // Table lookup; bytes outside the table read as all ones.
    always @*
    begin
        word_nxt = `FSW_TBL_FILL;
        if (addr[23:3] == `FSW_TBL_BASE)
        begin
            case (addr[2:0])
                3'h0: word_nxt = `FSW_TBL_B80;                      // see [RL17]
                3'h1: word_nxt = LARGE_BLOCK ? `FSW_TBL_B81_LB
                                             : `FSW_TBL_B81_STD;    // see [RL18] see [RL19]
                3'h2: word_nxt = `FSW_TBL_B82;                      // see [RL20]
                3'h3: word_nxt = `FSW_TBL_B83;                      // see [RL20]
                3'h4: word_nxt = `FSW_TBL_ER1;                      // see [RL21]
                3'h5: word_nxt = `FSW_TBL_ER2;                      // see [RL21]
                3'h6: word_nxt = LARGE_BLOCK ? `FSW_TBL_ER4 : `FSW_TBL_ER3;
                3'h7: word_nxt = LARGE_BLOCK ? `FSW_TBL_ER3 : `FSW_TBL_ER4;
                default: word_nxt = `FSW_TBL_FILL;
            endcase
        end
    end

    // Registered read port.
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rd_data <= `FSW_TBL_FILL;
        else
            rd_data <= word_nxt;
    end

endmodule // fsw_param_rom

// ### bench/fsw_status_properties.sv
`timescale 1ns/1ps

// ============================================================
// Port-level checker for the status and write-latch block.
module fsw_status_chk (
    input wire       clk,
    input wire       nrst,
    input wire       cs_n,
    input wire       so_oe_n,
    input wire       op_done,
    input wire       op_start,
    input wire [7:0] op_code,
    input wire [7:0] nv_wdata,
    input wire       suspend,
    input wire       write_busy,
    input wire       write_enable_latch,
    input wire [5:0] nv_bits,
    input wire       pin_ctl_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Busy rises only with a launch and falls on the engine's completion.
    property p_busy_rise; $rose(write_busy) |-> op_start; endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy rose, no launch");
    property p_busy_fall; op_done && write_busy |=> !write_busy; endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy held after done");
    property p_wel_clear; op_done && write_busy |=> !write_enable_latch; endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("latch held after done");
    property p_start_wel; op_start |-> $past(write_enable_latch); endproperty
    a_start_wel: assert property (p_start_wel) else $error("launch without latch");
    property p_start_idle; op_start |-> write_busy && !$past(write_busy); endproperty
    a_start_idle: assert property (p_start_idle) else $error("launch while busy");
    property p_status_write_cmd;
        op_start && op_code == 8'h01 |-> nv_bits == nv_wdata[7:2] && nv_wdata[1:0] == 2'h0;
    endproperty
    a_status_write_cmd: assert property (p_status_write_cmd) else $error("status write image wrong");
    property p_erase_bp;
        op_start && (op_code == 8'hc7 || op_code == 8'h60) |-> nv_bits[3:0] == 4'h0;
    endproperty
    a_erase_bp: assert property (p_erase_bp) else $error("erase with protect set");
    property p_suspend; suspend |-> write_busy && op_code != 8'h01; endproperty
    a_suspend: assert property (p_suspend) else $error("suspend out of place");
    property p_quad; $stable(nv_bits) |-> pin_ctl_en == !nv_bits[4]; endproperty
    a_quad: assert property (p_quad) else $error("pin role mismatch");
    property p_oe_idle; cs_n [*6] |-> so_oe_n; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output on while deselected");
endmodule // fsw_status_chk

bind fsw_status fsw_status_chk i_fsw_status_chk (.clk(clk), .nrst(nrst), .cs_n(cs_n),
    .so_oe_n(so_oe_n), .op_done(op_done), .op_start(op_start), .op_code(op_code),
    .nv_wdata(nv_wdata), .suspend(suspend), .write_busy(write_busy),
    .write_enable_latch(write_enable_latch), .nv_bits(nv_bits), .pin_ctl_en(pin_ctl_en));

// ### bench/fsw_spi_host.sv
`timescale 1ns/1ps

// ============================================================
// Serial host model: mode 0, MSB first, link clock still outside frames.
module fsw_spi_host (
    input  wire clk,
    output reg  sck,
    output reg  cs_n,
    output reg  si,
    input  wire so,
    input  wire so_lb
);
    logic [7:0] tx [0:15];
    logic [7:0] rx [0:15];
    logic [7:0] rx_lb [0:15];

    // One half period of the 800 ns link clock.
    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    // Sends n bytes from tx and captures n bytes into rx.
    task automatic run(input int n);
        int b;
        int k;
        @(negedge clk);
        cs_n = 1'b0;
        for (b = 0; b < n; b++)
            for (k = 7; k >= 0; k--)
            begin
                si = tx[b][k];
                half();
                sck = 1'b1;
                half();
                rx[b][k] = so;
                rx_lb[b][k] = so_lb;
                sck = 1'b0;
            end
        half();
        si = ~si;
        cs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask

    // Idle levels before the first frame.
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        foreach (tx[i]) tx[i] = 8'h00;
    end
endmodule // fsw_spi_host

// ### bench/fsw_status_test.sv
`timescale 1ns/1ps

// ============================================================
// Self-checking bench for the status and write-latch block.
module fsw_status_test;
    logic       clk, nrst, wp_n, op_done;
    logic [5:0] nv_image;
    wire        sck, cs_n, si, so, so_lb, so_oe_n, op_start, suspend, sw_reset;
    wire        write_busy, write_enable_latch, pin_ctl_en;
    wire  [7:0] op_code, nv_wdata;
    wire  [5:0] nv_bits;
    int         err_total, total_checks, cyc, n_start, n_susp, n_rst;
    logic [7:0] tbl [0:7] = '{8'hff, 8'hee, 8'hff, 8'hff, 8'h21, 8'h5c, 8'hdc, 8'hff};
    logic [7:0] tbl_lb [0:7] = '{8'hff, 8'hf6, 8'hff, 8'hff, 8'h21, 8'h5c, 8'hff, 8'hdc};

    fsw_status i_fsw_status (.clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
        .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .nv_image(nv_image), .op_done(op_done),
        .op_start(op_start), .op_code(op_code), .nv_wdata(nv_wdata), .suspend(suspend),
        .sw_reset(sw_reset), .write_busy(write_busy),
        .write_enable_latch(write_enable_latch), .nv_bits(nv_bits), .pin_ctl_en(pin_ctl_en));
    fsw_spi_host i_fsw_spi_host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si),
        .so(so | so_oe_n), .so_lb(so_lb));
    fsw_status #(.LARGE_BLOCK(1)) i_fsw_status_lb (.clk(clk), .nrst(nrst), .sck(sck),
        .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so_lb), .so_oe_n(), .nv_image(nv_image),
        .op_done(op_done), .op_start(), .op_code(), .nv_wdata(), .suspend(), .sw_reset(),
        .write_busy(), .write_enable_latch(), .nv_bits(), .pin_ctl_en());

    // System clock at 10 MHz.
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Counts launch, suspend and reset pulses; cuts a hang short.
    always @(posedge clk)
    begin
        cyc++;
        n_start += (op_start === 1'b1);
        n_susp += (suspend === 1'b1);
        n_rst += (sw_reset === 1'b1);
        if (cyc == 40000)
        begin
            err_total++;
            stop_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n);
        i_fsw_spi_host.tx[0] = op;
        i_fsw_spi_host.tx[1] = d;
        i_fsw_spi_host.run(n);
    endtask

    // Reads status twice in one frame; both copies must match.
    task automatic rdsr(input logic [7:0] exp);
        cmd(8'h05, 8'h00, 3);
        check(i_fsw_spi_host.rx[1], exp);
        check(i_fsw_spi_host.rx[2], exp);
    endtask

    task automatic done();
        op_done = 1'b1;
        @(negedge clk);
        op_done = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic t_reset();
        rdsr(8'h44);
        check({7'h0, pin_ctl_en}, 8'h00);
    endtask

    task automatic t_latch();
        cmd(8'h5c, 8'h00, 2);
        check(n_start, 0);
        cmd(8'h01, 8'h5f, 2);
        check(n_start, 0);
        cmd(8'h06, 8'h00, 1);
        rdsr(8'h46);
        cmd(8'h04, 8'h00, 1);
        rdsr(8'h44);
    endtask

    task automatic t_status_write();
        cmd(8'h06, 8'h00, 1);
        cmd(8'h01, 8'h5f, 2);
        check(nv_wdata, 8'h5c);
        check(op_code, 8'h01);
        rdsr(8'h5f);
        cmd(8'h04, 8'h00, 1);
        rdsr(8'h5f);
        done();
        rdsr(8'h5c);
        check({7'h0, pin_ctl_en}, 8'h00);
    endtask

    task automatic t_erase();
        cmd(8'h06, 8'h00, 1);
        cmd(8'hc7, 8'h00, 1);
        check(n_start, 1);
        cmd(8'h01, 8'h00, 2);
        done();
        cmd(8'h06, 8'h00, 1);
        cmd(8'h60, 8'h00, 1);
        check(op_code, 8'h60);
        cmd(8'h75, 8'h00, 1);
        check(n_susp, 1);
        done();
        rdsr(8'h00);
        check({7'h0, pin_ctl_en}, 8'h01);
        check(n_start, 3);
    endtask

    task automatic t_lock();
        cmd(8'h06, 8'h00, 1);
        cmd(8'h01, 8'h80, 2);
        done();
        wp_n = 1'b0;
        cmd(8'h06, 8'h00, 1);
        cmd(8'h01, 8'h04, 2);
        check({2'h0, nv_bits}, 8'h20);
        check(n_start, 4);
        wp_n = 1'b1;
        cmd(8'h01, 8'h00, 2);
        done();
        rdsr(8'h00);
        cmd(8'h66, 8'h00, 1);
        cmd(8'h99, 8'h00, 1);
        check(n_rst, 1);
    endtask

    // Reads the eight table bytes from 80h after one dummy byte.
    task automatic t_table();
        int i;
        i_fsw_spi_host.tx[0] = 8'h5a;
        i_fsw_spi_host.tx[1] = 8'h00;
        i_fsw_spi_host.tx[2] = 8'h00;
        i_fsw_spi_host.tx[3] = 8'h80;
        i_fsw_spi_host.tx[4] = 8'h00;
        i_fsw_spi_host.run(13);
        for (i = 0; i < 8; i++)
        begin
            check(i_fsw_spi_host.rx[5 + i], tbl[i]);
            check(i_fsw_spi_host.rx_lb[5 + i], tbl_lb[i]);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Reset, then every scenario in turn.
    initial
    begin
        nrst = 1'b0;
        wp_n = 1'b1;
        op_done = 1'b0;
        nv_image = 6'h11;
        repeat (3) @(negedge clk);
        check({2'h0, nv_bits}, 8'h00);
        nrst = 1'b1;
        repeat (6) @(negedge clk);
        t_reset();
        t_latch();
        t_status_write();
        t_erase();
        t_lock();
        t_table();
        stop_test();
    end
endmodule // fsw_status_test
